// ---- shared/egt_map.svh ----
// register map, field positions, reset values and timing counts of the trim block
`ifndef EGT_MAP_SVH
`define EGT_MAP_SVH
`define EGT_OFF_GAIN 8'h00
`define EGT_OFF_OFFS 8'h04
`define EGT_OFF_PHASE 8'h08
`define EGT_OFF_NUM 8'h0c
`define EGT_OFF_DEN 8'h10
`define EGT_OFF_HCC 8'h14
`define EGT_OFF_CTRL 8'h18
`define EGT_OFF_STAT 8'h1c
`define EGT_OFF_ENERGY 8'h20
`define EGT_OFF_LINE 8'h24
`define EGT_OFF_PERIOD 8'h28
`define EGT_CTRL_LINE_EN 0
`define EGT_STAT_LINE_DONE 0
`define EGT_RST_GAIN 12'h000
`define EGT_RST_OFFS 16'h0000
`define EGT_RST_PHASE 6'h0d
`define EGT_RST_NUM 12'h03f
`define EGT_RST_DEN 12'h03f
`define EGT_RST_HCC 16'hffff
`define EGT_PHASE_ZERO 6'h0d
`define EGT_GAIN_SHIFT 12
`define EGT_ACC_FRAC 8
`define EGT_VIS_LSB 33
`define EGT_ACC_CYC 4
`define EGT_STEP_CYC 8
`define EGT_PULSE_CYC 16
`endif

// ---- shared/egt_pkg.sv ----
// types shared by the trim block
package egt_pkg;
  typedef logic signed [15:0] egt_sample_t;
  typedef logic signed [11:0] egt_gain_t;
  typedef logic signed [15:0] egt_offs_t;
  typedef logic signed [5:0] egt_phase_t;
  typedef logic [23:0] egt_energy_t;
  typedef enum logic [1:0] {LC_IDLE, LC_ARM, LC_RUN} egt_line_state_t;
endpackage : egt_pkg

// ---- shared/egt_shift_if.sv ----
// sample path between the trim core and the phase shifter
`timescale 1ns/1ps
interface egt_shift_if;
  import egt_pkg::*;
  logic step;
  egt_phase_t phase_trim;
  egt_sample_t volt_in;
  egt_sample_t curr_in;
  egt_sample_t volt_out;
  egt_sample_t curr_out;
  modport core (output step, output phase_trim, output volt_in, output curr_in, input volt_out, input curr_out);
  modport shifter (input step, input phase_trim, input volt_in, input curr_in, output volt_out, output curr_out);
endinterface : egt_shift_if

// ---- hw/egt_phase_shift.sv ----
// voltage delay line with trim tap, current delayed by a fixed tap
`timescale 1ns/1ps
`include "egt_map.svh"
module egt_phase_shift #(
  parameter int DEPTH = 64
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  egt_shift_if.shifter sh
);
  import egt_pkg::*;
  egt_sample_t vline_ff [0:DEPTH-1];
  egt_sample_t cline_ff [0:DEPTH-1];
  egt_sample_t volt_ff;
  egt_sample_t curr_ff;
  localparam int CTAP = DEPTH / 2 + `EGT_PHASE_ZERO;
  logic [5:0] tap;

  // ---------------------------------
  // delay lines
  // ---------------------------------
  // advance is only relative: current sits 45 taps deep, so the whole signed trim range is usable
  assign tap = {~sh.phase_trim[5], sh.phase_trim[4:0]};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int k = 0; k < DEPTH; k++) begin
        vline_ff[k] <= 16'sh0000;
        cline_ff[k] <= 16'sh0000;
      end
    end else if (ce && sh.step) begin
      vline_ff[0] <= sh.volt_in;
      cline_ff[0] <= sh.curr_in;
      for (int k = 1; k < DEPTH; k++) begin
        vline_ff[k] <= vline_ff[k-1];
        cline_ff[k] <= cline_ff[k-1];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      volt_ff <= 16'sh0000;
      curr_ff <= 16'sh0000;
    end else if (ce) begin
      volt_ff <= vline_ff[tap];
      curr_ff <= cline_ff[CTAP];
    end
  end
  assign sh.volt_out = volt_ff;
  assign sh.curr_out = curr_ff;

  property p_vtap;
    @(posedge clk) disable iff (!rst_n) ce |=> volt_ff == $past(vline_ff[DEPTH / 2 + int'(sh.phase_trim)]);
  endproperty
  a_vtap: assert property (p_vtap) else $error("voltage tap mismatch");
  property p_shift;
    @(posedge clk) disable iff (!rst_n) ce && sh.step |=> vline_ff[1] == $past(vline_ff[0]);
  endproperty
  a_shift: assert property (p_shift) else $error("voltage line did not shift");
endmodule : egt_phase_shift

// ---- hw/egt_pulse_div.sv ----
// rational pulse divider driving the energy pulse pin
`timescale 1ns/1ps
`include "egt_map.svh"
module egt_pulse_div #(
  parameter int W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tick,
  input wire logic [W-1:0] num,
  input wire logic [W-1:0] den,
  output logic pulse
);
  logic [W+1:0] acc_ff;
  logic [W+1:0] sum;
  logic [4:0] wid_ff;

  assign sum = acc_ff + {2'b00, num} + {{W+1{1'b0}}, 1'b1};
  // each tick adds num+1, each pulse removes den+1
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_ff <= '0;
    end else if (ce && tick) begin
      if (sum >= {2'b00, den} + {{W+1{1'b0}}, 1'b1}) begin
        acc_ff <= sum - {2'b00, den} - {{W+1{1'b0}}, 1'b1};
      end else begin
        acc_ff <= sum;
      end
    end
  end
  // a new pulse inside the width window restarts it, so very high rates merge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wid_ff <= 5'h00;
    end else if (ce) begin
      if (tick && sum >= {2'b00, den} + {{W+1{1'b0}}, 1'b1}) begin
        wid_ff <= 5'(`EGT_PULSE_CYC);
      end else if (wid_ff != 5'h00) begin
        wid_ff <= wid_ff - 5'h01;
      end
    end
  end
  assign pulse = wid_ff != 5'h00;

  property p_fire;
    @(posedge clk) disable iff (!rst_n)
      ce && tick && (acc_ff + num + 1 >= den + 1) |=> pulse && wid_ff == 5'(`EGT_PULSE_CYC);
  endproperty
  a_fire: assert property (p_fire) else $error("pulse missed");
endmodule : egt_pulse_div

// ---- hw/egt_trim_top.sv ----
// active energy trim core: gain, offset, phase, line-cycle accumulation and APB registers
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "egt_map.svh"
module egt_trim_top #(
  parameter int ACC_W = 57
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire egt_pkg::egt_sample_t VOLT_SAMPLE,
  input wire egt_pkg::egt_sample_t CURR_SAMPLE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic ENERGY_PULSE_OUTPUT
);
  import egt_pkg::*;

  // ---------------------------------
  // registers and state
  // ---------------------------------
  egt_gain_t active_power_gain_trim_ff;
  egt_offs_t active_power_offset_trim_ff;
  egt_phase_t voltage_phase_trim_ff;
  logic [11:0] pulse_divider_numerator_ff;
  logic [11:0] pulse_divider_denominator_ff;
  logic [15:0] half_cycle_count_ff;
  logic line_en_ff;
  logic line_done_ff;
  logic [31:0] prdata_ff;
  logic [1:0] quarter_ff;
  logic [2:0] step_cnt_ff;
  logic signed [31:0] power_ff;
  logic signed [31:0] gained_ff;
  logic signed [ACC_W-1:0] acc_ff;
  egt_energy_t vis_prev_ff;
  logic tick_ff;
  egt_energy_t line_start_ff;
  egt_energy_t line_cycle_active_energy_ff;
  logic [15:0] hc_cnt_ff;
  logic [15:0] period_cnt_ff;
  logic [15:0] period_ff;
  logic sign_prev_ff;
  egt_line_state_t line_st_ff;
  egt_line_state_t nxt_line_st;
  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  logic stat_clear;
  logic update;
  logic crossing;
  logic rising;
  logic signed [43:0] gain_prod;
  logic signed [ACC_W-1:0] nxt_acc;
  egt_energy_t active_energy_accumulator;

  egt_shift_if shf ();

  function automatic egt_energy_t visible(input logic signed [ACC_W-1:0] a);
    visible = a[`EGT_VIS_LSB +: 24];
  endfunction : visible

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = a <= `EGT_OFF_PERIOD && a[1:0] == 2'b00;
  endfunction : known_addr

  // ---------------------------------
  // apb slave
  // ---------------------------------
  // zero wait states: write lands at the access edge, read data is caught in setup
  assign wr_en = CE && PSEL && PENABLE && PWRITE && addr_ok;
  assign rd_setup = CE && PSEL && !PENABLE && !PWRITE;
  assign addr_ok = known_addr(PADDR);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
  assign PRDATA = prdata_ff;
  assign stat_clear = wr_en && PADDR == `EGT_OFF_STAT && PWDATA[`EGT_STAT_LINE_DONE];

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      active_power_gain_trim_ff <= `EGT_RST_GAIN;
      active_power_offset_trim_ff <= `EGT_RST_OFFS;
      voltage_phase_trim_ff <= `EGT_RST_PHASE;
      pulse_divider_numerator_ff <= `EGT_RST_NUM;
      pulse_divider_denominator_ff <= `EGT_RST_DEN;
      half_cycle_count_ff <= `EGT_RST_HCC;
      line_en_ff <= 1'b0;
    end else if (wr_en) begin
      // new values steer the datapath from the next cycle on
      unique case (PADDR)
        `EGT_OFF_GAIN: active_power_gain_trim_ff <= PWDATA[11:0];
        `EGT_OFF_OFFS: active_power_offset_trim_ff <= PWDATA[15:0];
        `EGT_OFF_PHASE: voltage_phase_trim_ff <= PWDATA[5:0];
        `EGT_OFF_NUM: pulse_divider_numerator_ff <= PWDATA[11:0];
        `EGT_OFF_DEN: pulse_divider_denominator_ff <= PWDATA[11:0];
        `EGT_OFF_HCC: half_cycle_count_ff <= PWDATA[15:0];
        `EGT_OFF_CTRL: line_en_ff <= PWDATA[`EGT_CTRL_LINE_EN];
        default: ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (PADDR)
        `EGT_OFF_GAIN: prdata_ff <= {{20{active_power_gain_trim_ff[11]}}, active_power_gain_trim_ff};
        `EGT_OFF_OFFS: prdata_ff <= {{16{active_power_offset_trim_ff[15]}}, active_power_offset_trim_ff};
        `EGT_OFF_PHASE: prdata_ff <= {{26{voltage_phase_trim_ff[5]}}, voltage_phase_trim_ff};
        `EGT_OFF_NUM: prdata_ff <= {20'h00000, pulse_divider_numerator_ff};
        `EGT_OFF_DEN: prdata_ff <= {20'h00000, pulse_divider_denominator_ff};
        `EGT_OFF_HCC: prdata_ff <= {16'h0000, half_cycle_count_ff};
        `EGT_OFF_CTRL: prdata_ff <= {31'h0000_0000, line_en_ff};
        `EGT_OFF_STAT: prdata_ff <= {31'h0000_0000, line_done_ff};
        `EGT_OFF_ENERGY: prdata_ff <= {8'h00, active_energy_accumulator};
        `EGT_OFF_LINE: prdata_ff <= {8'h00, line_cycle_active_energy_ff};
        `EGT_OFF_PERIOD: prdata_ff <= {16'h0000, period_ff};
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------
  // phase trim path
  // ---------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      step_cnt_ff <= 3'h0;
    end else if (CE) begin
      step_cnt_ff <= step_cnt_ff + 3'h1;
    end
  end
  assign shf.step = step_cnt_ff == 3'(`EGT_STEP_CYC - 1);
  assign shf.phase_trim = voltage_phase_trim_ff;
  assign shf.volt_in = VOLT_SAMPLE;
  assign shf.curr_in = CURR_SAMPLE;

  egt_phase_shift #(
    .DEPTH(64)
  ) u_shift (
    .clk(REF_CLK),
    .rst_n(NRST),
    .ce(CE),
    .sh(shf.shifter)
  );

  // ---------------------------------
  // power, gain and offset
  // ---------------------------------
  assign gain_prod = 44'(power_ff) * 44'(active_power_gain_trim_ff);
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      power_ff <= 32'sh0000_0000;
      gained_ff <= 32'sh0000_0000;
    end else if (CE) begin
      power_ff <= 32'(shf.volt_out) * 32'(shf.curr_out);
      gained_ff <= power_ff + 32'(gain_prod >>> `EGT_GAIN_SHIFT);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      quarter_ff <= 2'h0;
    end else if (CE) begin
      quarter_ff <= quarter_ff + 2'h1;
    end
  end
  assign update = CE && quarter_ff == 2'(`EGT_ACC_CYC - 1);

  // power lands on bit 8; offset is added at bit 0, so its 16 bits reach up to bit 15 and overlap power
  assign nxt_acc = acc_ff + (ACC_W'(gained_ff) <<< `EGT_ACC_FRAC)
                   + ACC_W'(active_power_offset_trim_ff);
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      acc_ff <= '0;
    end else if (update) begin
      acc_ff <= nxt_acc;
    end
  end
  assign active_energy_accumulator = visible(acc_ff);

  // ---------------------------------
  // pulse output
  // ---------------------------------
  // one tick per visible increase; negative energy gives no pulses
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      vis_prev_ff <= 24'h000000;
      tick_ff <= 1'b0;
    end else if (CE) begin
      vis_prev_ff <= active_energy_accumulator;
      tick_ff <= $signed(active_energy_accumulator - vis_prev_ff) > 24'sh000000;
    end
  end

  egt_pulse_div #(
    .W(12)
  ) u_pulse (
    .clk(REF_CLK),
    .rst_n(NRST),
    .ce(CE),
    .tick(tick_ff),
    .num(pulse_divider_numerator_ff),
    .den(pulse_divider_denominator_ff),
    .pulse(ENERGY_PULSE_OUTPUT)
  );

  // ---------------------------------
  // line period
  // ---------------------------------
  assign crossing = CE && shf.step && (VOLT_SAMPLE[15] != sign_prev_ff);
  assign rising = crossing && !VOLT_SAMPLE[15];
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      sign_prev_ff <= 1'b0;
      period_cnt_ff <= 16'h0000;
      period_ff <= 16'h0000;
    end else if (CE && shf.step) begin
      sign_prev_ff <= VOLT_SAMPLE[15];
      if (rising) begin
        period_ff <= period_cnt_ff;
        period_cnt_ff <= 16'h0001;
      end else if (period_cnt_ff != 16'hffff) begin
        period_cnt_ff <= period_cnt_ff + 16'h0001;
      end
    end
  end

  // ---------------------------------
  // line-cycle accumulation
  // ---------------------------------
  always_comb begin
    nxt_line_st = line_st_ff;
    unique case (line_st_ff)
      LC_IDLE: if (line_en_ff) nxt_line_st = LC_ARM;
      LC_ARM: if (!line_en_ff) nxt_line_st = LC_IDLE; else if (crossing) nxt_line_st = LC_RUN;
      LC_RUN: if (!line_en_ff) nxt_line_st = LC_IDLE;
    endcase
  end
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      line_st_ff <= LC_IDLE;
    end else if (CE) begin
      line_st_ff <= nxt_line_st;
    end
  end

  // window restarts at every end, so back-to-back windows share their edges
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      hc_cnt_ff <= 16'h0000;
      line_start_ff <= 24'h000000;
      line_cycle_active_energy_ff <= 24'h000000;
    end else if (crossing && line_st_ff == LC_ARM) begin
      hc_cnt_ff <= 16'h0000;
      line_start_ff <= active_energy_accumulator;
    end else if (crossing && line_st_ff == LC_RUN) begin
      if (hc_cnt_ff + 16'h0001 >= half_cycle_count_ff) begin
        hc_cnt_ff <= 16'h0000;
        line_start_ff <= active_energy_accumulator;
        line_cycle_active_energy_ff <= active_energy_accumulator - line_start_ff;
      end else begin
        hc_cnt_ff <= hc_cnt_ff + 16'h0001;
      end
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      line_done_ff <= 1'b0;
    end else if (crossing && line_st_ff == LC_RUN && hc_cnt_ff + 16'h0001 >= half_cycle_count_ff) begin
      line_done_ff <= 1'b1;
    end else if (stat_clear) begin
      line_done_ff <= 1'b0;
    end
  end

  // ---------------------------------
  // checks
  // ---------------------------------
  property p_acc_rate;
    @(posedge REF_CLK) disable iff (!NRST) CE && !update |=> $stable(acc_ff);
  endproperty
  a_acc_rate: assert property (p_acc_rate) else $error("accumulator moved off its slot");
  property p_acc_sum;
    @(posedge REF_CLK) disable iff (!NRST)
      update |=> acc_ff == $past(acc_ff) + ($past(ACC_W'(gained_ff)) <<< 8) + $past(ACC_W'(active_power_offset_trim_ff));
  endproperty
  a_acc_sum: assert property (p_acc_sum) else $error("offset or power not accumulated");
  property p_gain;
    @(posedge REF_CLK) disable iff (!NRST)
      CE && active_power_gain_trim_ff == 12'sh000 |=> gained_ff == $past(power_ff);
  endproperty
  a_gain: assert property (p_gain) else $error("zero gain trim changed power");
  property p_gain_apply;
    @(posedge REF_CLK) disable iff (!NRST)
      wr_en && PADDR == `EGT_OFF_GAIN |=> active_power_gain_trim_ff == $past(PWDATA[11:0]);
  endproperty
  a_gain_apply: assert property (p_gain_apply) else $error("gain write not taken");
  property p_step;
    @(posedge REF_CLK) disable iff (!NRST) CE && shf.step |-> ##1 !shf.step [*7];
  endproperty
  a_step: assert property (p_step) else $error("shift step not eight clocks");
  property p_done_sticky;
    @(posedge REF_CLK) disable iff (!NRST) line_done_ff && !stat_clear |=> line_done_ff;
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done flag lost");
  property p_slverr;
    @(posedge REF_CLK) disable iff (!NRST) PSEL && PENABLE && PADDR == 8'hfc |-> PSLVERR && PREADY;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped address not flagged");
endmodule : egt_trim_top

// ---- test/egt_host.sv ----
// host model: apb master that programs and reads the trim registers
`timescale 1ns/1ps
module egt_host (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // ----------------------------------------
  // one transfer: setup, access until ready
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no fixed wait state count assumed
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data lines must not look valid
    pwdata <= ~d;
  endtask : xfer
endmodule : egt_host

// ---- test/tb.sv ----
// testbench of the trim block: registers, gain, phase, pulse divider, line mode
`timescale 1ns/1ps
`include "egt_map.svh"
`define CHECK(g, x) \
  begin \
    comparisons++; \
    if ((g) !== (x)) begin \
      num_errors++; \
      $display("MISMATCH t=%0t got %h exp %h", $time, g, x); \
    end \
  end
module tb;
  import egt_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic sq_en = 1'b0;
  egt_sample_t volt = '0;
  egt_sample_t curr = '0;
  logic psel, penable, pwrite, pready, pslverr, pulse, pulse_q, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, r;
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int rises = 0;
  int r0, n;
  int lat [7];
  logic [7:0] ra [7] = '{`EGT_OFF_GAIN, `EGT_OFF_OFFS, `EGT_OFF_PHASE, `EGT_OFF_NUM, `EGT_OFF_DEN,
                         `EGT_OFF_HCC, `EGT_OFF_CTRL};
  logic [31:0] rv [7] = '{32'(`EGT_RST_GAIN), 32'(`EGT_RST_OFFS), 32'(`EGT_RST_PHASE), 32'(`EGT_RST_NUM),
                          32'(`EGT_RST_DEN), 32'(`EGT_RST_HCC), 32'h0};
  logic [7:0] sa [3] = '{`EGT_OFF_GAIN, `EGT_OFF_OFFS, `EGT_OFF_PHASE};
  logic [31:0] sw [3] = '{32'h800, 32'h8000, 32'h3f};
  logic [31:0] sx [3] = '{32'hfffff800, 32'hffff8000, 32'hffffffff};
  logic [5:0] ph [7] = '{6'h0d, 6'h0e, 6'h0c, 6'h0f, 6'h3f, 6'h0d, 6'h0f};
  logic vs [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [11:0] gg [4] = '{12'h000, 12'h400, 12'h800, 12'h000};
  logic [15:0] gc [4] = '{16'h4000, 16'h4000, 16'h4000, 16'hc000};
  logic [23:0] ge [4] = '{24'd800, 24'd1000, 24'd400, 24'hfffce0};
  logic [11:0] pn [5] = '{12'h0, 12'h1, 12'h0, 12'h3, 12'h0};
  logic [11:0] pd [5] = '{12'h7, 12'hf, 12'hf, 12'h1f, 12'h7};
  logic [15:0] pc [5] = '{16'h4000, 16'h4000, 16'h4000, 16'h4000, 16'hc000};
  int px [5] = '{20, 20, 10, 20, 0};

  always #12.5 clk = ~clk;

  // ----------------------------------------
  // pulse edge counter and square line drive
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pulse_q <= pulse;
    if (pulse === 1'b1 && pulse_q === 1'b0) begin
      rises <= rises + 1;
    end
    // both channels flip together, so power stays positive
    if (sq_en && cyc % 128 == 127) begin
      volt <= -volt;
      curr <= -curr;
    end
  end

  egt_trim_top egt_trim_top_i (
    .REF_CLK(clk), .NRST(nrst), .CE(ce), .VOLT_SAMPLE(volt), .CURR_SAMPLE(curr),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ENERGY_PULSE_OUTPUT(pulse)
  );

  egt_host egt_host_i (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dq;
    logic de;
    egt_host_i.xfer(1'b1, a, d, dq, de);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] dq, output logic de);
    egt_host_i.xfer(1'b0, a, 32'h0, dq, de);
  endtask : rd

  task close_out;
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    close_out();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], q, e);
      `CHECK(q, rv[i])
    end
    rd(8'h2c, q, e);
    `CHECK({e, q}, 33'h100000000)
    rd(8'h01, q, e);
    `CHECK({e, q}, 33'h100000000)
    for (int i = 0; i < 3; i++) begin
      wr(sa[i], sw[i]);
      rd(sa[i], q, e);
      `CHECK(q, sx[i])
      wr(sa[i], rv[i]);
    end
    // a write while the clock enable is low must be lost
    ce <= 1'b0;
    wr(`EGT_OFF_GAIN, 32'h123);
    ce <= 1'b1;
    rd(`EGT_OFF_GAIN, q, e);
    `CHECK(q, 32'h0)
    // latency of the first pulse after a step; loop length fixed so counters realign
    curr <= 16'sh4000;
    repeat (300) @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      wr(`EGT_OFF_PHASE, 32'(ph[i]));
      @(posedge clk);
      if (vs[i]) volt <= 16'sh4000;
      else curr <= 16'sh4000;
      n = 0;
      while (pulse !== 1'b1 && n < 600) begin
        @(negedge clk);
        n++;
      end
      lat[i] = n;
      @(posedge clk);
      volt <= (i < 4) ? 16'sh0 : 16'sh4000;
      curr <= (i < 4) ? 16'sh4000 : 16'sh0;
      // long enough to flush the deepest tap before the next step
      repeat (1020 - n) @(posedge clk);
    end
    `CHECK(lat[1] - lat[0], 8)
    `CHECK(lat[2] - lat[0], -8)
    `CHECK(lat[3] - lat[0], 16)
    `CHECK(lat[4] - lat[0], -112)
    `CHECK(lat[6] - lat[5], 0)
    wr(`EGT_OFF_PHASE, 32'h0d);
    volt <= 16'sh4000;
    // 400 cycles between read latches: 100 accumulator updates
    for (int i = 0; i < 4; i++) begin
      curr <= gc[i];
      wr(`EGT_OFF_GAIN, 32'(signed'(gg[i])));
      repeat (500) @(posedge clk);
      rd(`EGT_OFF_ENERGY, r, e);
      repeat (397) @(posedge clk);
      rd(`EGT_OFF_ENERGY, q, e);
      `CHECK(24'(q - r), ge[i])
    end
    for (int i = 0; i < 5; i++) begin
      curr <= pc[i];
      wr(`EGT_OFF_NUM, 32'(pn[i]));
      wr(`EGT_OFF_DEN, 32'(pd[i]));
      repeat (500) @(posedge clk);
      r0 = rises;
      repeat (640) @(posedge clk);
      `CHECK(rises - r0, px[i])
    end
    // square line of 256 cycles, four half cycles per window
    volt <= 16'sh4000;
    curr <= 16'sh4000;
    // let the old negative current leave the delay line first
    repeat (500) @(posedge clk);
    sq_en <= 1'b1;
    wr(`EGT_OFF_HCC, 32'h4);
    wr(`EGT_OFF_STAT, 32'h1);
    wr(`EGT_OFF_CTRL, 32'h1);
    repeat (600) @(posedge clk);
    rd(`EGT_OFF_PERIOD, q, e);
    `CHECK(q, 32'd32)
    for (n = 0; n < 400 && q[0] !== 1'b1; n++) rd(`EGT_OFF_STAT, q, e);
    rd(`EGT_OFF_LINE, q, e);
    `CHECK(q, 32'h400)
    wr(`EGT_OFF_STAT, 32'h1);
    rd(`EGT_OFF_STAT, q, e);
    `CHECK(q[0], 1'b0)
    close_out();
  end
endmodule : tb
